// file: hdl/cfr_pkg.sv
// shared constants and types of the crest factor reduction port block
package cfr_pkg;

  // antenna slots and control field widths
  localparam int unsigned MAX_ANT     = 4;
  localparam int unsigned SPAN_W      = 5;
  localparam int unsigned BANK_W      = 2;
  localparam int unsigned NUM_BANKS   = 4;
  localparam int unsigned SCALE_W     = 16;
  localparam int unsigned SCALE_FRAC  = 13;
  localparam int unsigned WEIGHT_W    = 8;
  localparam int unsigned WEIGHT_FRAC = 8;
  localparam int unsigned HITCNT_W    = 16;

  // register byte offsets on the avalon slave
  localparam logic [7:0] REG_CLIP    = 8'h00;
  localparam logic [7:0] REG_SPAN    = 8'h04;
  localparam logic [7:0] REG_BANK    = 8'h08;
  localparam logic [7:0] REG_SCALE   = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_WEIGHT0 = 8'h20;
  localparam logic [7:0] REG_WSTEP   = 8'h04;

  // status register field positions
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_CNT_LSB   = 16;

  // reset values
  localparam logic [SPAN_W-1:0]   SPAN_RST    = 5'h03;
  localparam logic [BANK_W-1:0]   BANK_RST    = 2'h0;
  localparam logic [SCALE_W-1:0]  SCALE_UNITY = 16'h2000;
  localparam logic [WEIGHT_W-1:0] WEIGHT_RST0 = 8'h40;
  localparam logic [WEIGHT_W-1:0] WEIGHT_RST1 = 8'h60;
  localparam logic [WEIGHT_W-1:0] WEIGHT_RST2 = 8'h80;
  localparam logic [WEIGHT_W-1:0] WEIGHT_RST3 = 8'hA0;

  // interleaved output sequencer
  typedef enum logic [1:0] {
    CFR_OUT_IDLE  = 2'b01,
    CFR_OUT_QPEND = 2'b10
  } cfr_out_state_t;

endpackage

// file: hdl/cfr_clip_if.sv
// carrier between the port logic and the peak clipper
`timescale 1ns/1ps
interface cfr_clip_if #(
  parameter int unsigned IW = 16
);
  import cfr_pkg::*;

  logic                        ce;
  logic                        reinit;
  logic                        in_valid;
  logic signed [IW-1:0]        in_i     [MAX_ANT];
  logic signed [IW-1:0]        in_q     [MAX_ANT];
  logic        [IW-1:0]        clip;
  logic        [SPAN_W-1:0]    span;
  logic        [WEIGHT_W-1:0]  weight;
  logic                        res_valid;
  logic signed [IW-1:0]        res_i    [MAX_ANT];
  logic signed [IW-1:0]        res_q    [MAX_ANT];
  logic                        hit;

  modport ports (
    output ce, reinit, in_valid, in_i, in_q, clip, span, weight,
    input  res_valid, res_i, res_q, hit
  );

  modport clipper (
    input  ce, reinit, in_valid, in_i, in_q, clip, span, weight,
    output res_valid, res_i, res_q, hit
  );
endinterface

// file: hdl/cfr_peak_clip.sv
// per-antenna peak detector and canceller, one register stage
`timescale 1ns/1ps
module cfr_peak_clip
  import cfr_pkg::*;
#(
  parameter int unsigned IW = 16
) (
  // clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // datapath carrier
  cfr_clip_if.clipper bus
);

  logic                 valid_q, valid_d;
  logic                 hit_q, hit_d;
  logic signed [IW-1:0] ri_q [MAX_ANT];
  logic signed [IW-1:0] ri_d [MAX_ANT];
  logic signed [IW-1:0] rq_q [MAX_ANT];
  logic signed [IW-1:0] rq_d [MAX_ANT];
  logic [SPAN_W-1:0]    hold_q [MAX_ANT];
  logic [SPAN_W-1:0]    hold_d [MAX_ANT];

  // magnitude of a two's complement word, one bit wider so the minimum fits
  function automatic logic [IW:0] mag(input logic signed [IW-1:0] v);
    logic signed [IW:0] w;
    w = {v[IW-1], v};
    mag = w[IW] ? $unsigned(-w) : $unsigned(w);
  endfunction

  // shrink a component by weight/256, toward zero
  function automatic logic signed [IW-1:0] cancel(input logic signed [IW-1:0] v,
                                                  input logic [WEIGHT_W-1:0] w);
    logic signed [IW+WEIGHT_W:0] p;
    p = v * $signed({1'b0, w});
    p = p >>> WEIGHT_FRAC;
    cancel = v - p[IW-1:0];
  endfunction

  // next state: amplitude estimate max+min/2 is cheap and never under-reads by more than half an LSB
  always_comb begin
    logic [IW:0]   ai;
    logic [IW:0]   aq;
    logic [IW+1:0] est;
    logic          any;
    ai      = '0;
    aq      = '0;
    est     = '0;
    any     = 1'b0;
    valid_d = valid_q;
    hit_d   = hit_q;
    ri_d    = ri_q;
    rq_d    = rq_q;
    hold_d  = hold_q;
    if (bus.reinit) begin
      valid_d = 1'b0;
      hit_d   = 1'b0;
      for (int a = 0; a < MAX_ANT; a++) begin
        ri_d[a]   = '0;
        rq_d[a]   = '0;
        hold_d[a] = '0;
      end
    end else begin
      valid_d = bus.in_valid;
      hit_d   = 1'b0;
      if (bus.in_valid) begin
        for (int a = 0; a < MAX_ANT; a++) begin
          ai  = mag(bus.in_i[a]);
          aq  = mag(bus.in_q[a]);
          est = (ai > aq) ? ({1'b0, ai} + {2'b00, aq[IW:1]})
                          : ({1'b0, aq} + {2'b00, ai[IW:1]});
          // peaks above the threshold are cancelled
          if (est > {2'b00, bus.clip} && hold_q[a] == '0) begin
            ri_d[a]   = cancel(bus.in_i[a], bus.weight);
            rq_d[a]   = cancel(bus.in_q[a], bus.weight);
            hold_d[a] = bus.span;
            any       = 1'b1;
          end else begin
            // inside the window only the first peak is treated
            ri_d[a] = bus.in_i[a];
            rq_d[a] = bus.in_q[a];
            if (hold_q[a] != '0) begin
              hold_d[a] = hold_q[a] - 1'b1;
            end
          end
        end
        hit_d = any;
      end
    end
  end

  // registers; a low enable freezes everything
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      valid_q <= 1'b0;
      hit_q   <= 1'b0;
      for (int a = 0; a < MAX_ANT; a++) begin
        ri_q[a]   <= '0;
        rq_q[a]   <= '0;
        hold_q[a] <= '0;
      end
    end else if (bus.ce) begin
      valid_q <= valid_d;
      hit_q   <= hit_d;
      ri_q    <= ri_d;
      rq_q    <= rq_d;
      hold_q  <= hold_d;
    end
  end

  assign bus.res_valid = valid_q;
  assign bus.res_i     = ri_q;
  assign bus.res_q     = rq_q;
  assign bus.hit       = hit_q;

endmodule

// file: hdl/cfr_ports.sv
// top of the crest factor reduction ports: stream in/out, controls, registers
`timescale 1ns/1ps
module cfr_ports
  import cfr_pkg::*;
#(
  parameter int unsigned NUM_ANT    = 1,
  parameter int unsigned IW         = 16,
  parameter int unsigned OW         = 16,
  parameter bit          IN_SPLIT   = 1'b1,
  parameter bit          OUT_SPLIT  = 1'b1,
  parameter bit          USE_CE     = 1'b0,
  parameter bit          USE_REINIT = 1'b0,
  parameter bit          USE_LIVE   = 1'b0
) (
  // clock, enable and resets
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_srst,
  input  wire logic                 i_ce,
  input  wire logic                 i_sync_reinit,
  // input stream
  input  wire logic                 i_input_valid,
  input  wire logic                 i_input_i_marker,
  input  wire logic signed [IW-1:0] i_antenna_i_in           [MAX_ANT],
  input  wire logic signed [IW-1:0] i_antenna_q_in           [MAX_ANT],
  input  wire logic signed [IW-1:0] i_antenna_interleaved_in [MAX_ANT],
  output logic                      o_ready_for_input,
  // live controls
  input  wire logic [IW-1:0]        i_clip_level,
  input  wire logic [SPAN_W-1:0]    i_peak_search_span,
  input  wire logic [BANK_W-1:0]    i_coefficient_bank_choice,
  input  wire logic [SCALE_W-1:0]   i_output_scale,
  // output stream
  output logic                      o_output_valid,
  output logic                      o_output_i_marker,
  output logic signed [OW-1:0]      o_antenna_i_out           [MAX_ANT],
  output logic signed [OW-1:0]      o_antenna_q_out           [MAX_ANT],
  output logic signed [OW-1:0]      o_antenna_interleaved_out [MAX_ANT],
  // avalon-mm register slave
  input  wire logic [7:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest
);

  // effective optional controls
  logic ce;
  logic reinit;
  assign ce     = USE_CE ? i_ce : 1'b1;
  assign reinit = i_srst | (USE_REINIT ? i_sync_reinit : 1'b0);

  cfr_clip_if #(.IW(IW)) clip_bus ();

  // ------------------------------------------------------------------
  // register file
  logic                 ack_q, ack_d;
  logic [31:0]          rdata_q, rdata_d;
  logic [IW-1:0]        clip_q, clip_d;
  logic [SPAN_W-1:0]    span_q, span_d;
  logic [BANK_W-1:0]    bank_q, bank_d;
  logic [SCALE_W-1:0]   scale_q, scale_d;
  logic [WEIGHT_W-1:0]  weight_q [NUM_BANKS];
  logic [WEIGHT_W-1:0]  weight_d [NUM_BANKS];
  logic [HITCNT_W-1:0]  hits_q, hits_d;
  logic                 req;
  logic                 ready;

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    be_merge = old;
  endfunction

  // zero-extend a narrow field to a bus word
  function automatic logic [31:0] zx(input logic [31:0] v, input int unsigned w);
    zx = v & ((32'h0000_0001 << w) - 32'h0000_0001);
  endfunction

  assign req               = i_avs_read | i_avs_write;
  // one wait state: the request is taken on the edge where ack_q is high
  assign o_avs_waitrequest = req & ~(ack_q & ce);  // a frozen edge must not look like an accept
  assign o_avs_readdata    = rdata_q;

  always_comb begin
    logic [31:0] wv;
    wv       = '0;
    ack_d    = req & ~ack_q;
    rdata_d  = rdata_q;
    clip_d   = clip_q;
    span_d   = span_q;
    bank_d   = bank_q;
    scale_d  = scale_q;
    weight_d = weight_q;
    // a detected peak counts even during a software read of the counter
    hits_d   = clip_bus.hit ? hits_q + 1'b1 : hits_q;
    if (req && !ack_q && i_avs_read) begin
      unique case (i_avs_address)
        REG_CLIP:   rdata_d = zx(32'(clip_q), IW);
        REG_SPAN:   rdata_d = zx(32'(span_q), SPAN_W);
        REG_BANK:   rdata_d = zx(32'(bank_q), BANK_W);
        REG_SCALE:  rdata_d = zx(32'(scale_q), SCALE_W);
        REG_STATUS: rdata_d = (32'(hits_q) << STAT_CNT_LSB) |
                              (32'(ready) << STAT_READY_BIT);
        default: begin
          rdata_d = '0;
          for (int k = 0; k < NUM_BANKS; k++) begin
            if (i_avs_address == REG_WEIGHT0 + 8'(k) * REG_WSTEP) begin
              rdata_d = zx(32'(weight_q[k]), WEIGHT_W);
            end
          end
        end
      endcase
    end
    if (req && ack_q && i_avs_write) begin
      // writes to unmapped or read-only words are dropped
      unique case (i_avs_address)
        REG_CLIP: begin
          wv     = be_merge(zx(32'(clip_q), IW), i_avs_writedata, i_avs_byteenable);
          clip_d = wv[IW-1:0];
        end
        REG_SPAN: begin
          wv     = be_merge(zx(32'(span_q), SPAN_W), i_avs_writedata, i_avs_byteenable);
          span_d = wv[SPAN_W-1:0];
        end
        REG_BANK: begin
          wv     = be_merge(zx(32'(bank_q), BANK_W), i_avs_writedata, i_avs_byteenable);
          bank_d = wv[BANK_W-1:0];
        end
        REG_SCALE: begin
          wv      = be_merge(zx(32'(scale_q), SCALE_W), i_avs_writedata, i_avs_byteenable);
          scale_d = wv[SCALE_W-1:0];
        end
        default: begin
          for (int k = 0; k < NUM_BANKS; k++) begin
            if (i_avs_address == REG_WEIGHT0 + 8'(k) * REG_WSTEP) begin
              wv = be_merge(zx(32'(weight_q[k]), WEIGHT_W), i_avs_writedata,
                            i_avs_byteenable);
              weight_d[k] = wv[WEIGHT_W-1:0];
            end
          end
        end
      endcase
    end
    // software settings survive a datapath reinit; only i_srst or the asynchronous i_rst_n clears them
    if (i_srst) begin
      ack_d    = 1'b0;
      rdata_d  = '0;
      clip_d   = '1;
      span_d   = SPAN_RST;
      bank_d   = BANK_RST;
      scale_d  = SCALE_UNITY;
      weight_d = '{WEIGHT_RST0, WEIGHT_RST1, WEIGHT_RST2, WEIGHT_RST3};
      hits_d   = '0;
    end else if (reinit) begin
      hits_d = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q    <= 1'b0;
      rdata_q  <= '0;
      clip_q   <= '1;
      span_q   <= SPAN_RST;
      bank_q   <= BANK_RST;
      scale_q  <= SCALE_UNITY;
      weight_q <= '{WEIGHT_RST0, WEIGHT_RST1, WEIGHT_RST2, WEIGHT_RST3};
      hits_q   <= '0;
    end else if (ce) begin
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      clip_q   <= clip_d;
      span_q   <= span_d;
      bank_q   <= bank_d;
      scale_q  <= scale_d;
      weight_q <= weight_d;
      hits_q   <= hits_d;
    end
  end

  // live inputs take over from the registers when built in
  logic [IW-1:0]      clip_use;
  logic [SPAN_W-1:0]  span_use;
  logic [BANK_W-1:0]  bank_use;
  logic [SCALE_W-1:0] scale_use;
  assign clip_use  = USE_LIVE ? i_clip_level              : clip_q;
  assign span_use  = USE_LIVE ? i_peak_search_span        : span_q;
  assign bank_use  = USE_LIVE ? i_coefficient_bank_choice : bank_q;
  assign scale_use = USE_LIVE ? i_output_scale            : scale_q;

  // ------------------------------------------------------------------
  // input capture: pairs I/Q into one word per antenna
  logic                 pv_q, pv_d;
  logic                 have_i_q, have_i_d;
  logic                 thr_q, thr_d;
  logic signed [IW-1:0] pi_q [MAX_ANT];
  logic signed [IW-1:0] pi_d [MAX_ANT];
  logic signed [IW-1:0] pq_q [MAX_ANT];
  logic signed [IW-1:0] pq_d [MAX_ANT];
  logic                 take;

  // split in, interleaved out needs two output cycles per pair, so throttle
  assign ready             = (IN_SPLIT && !OUT_SPLIT) ? ~thr_q : 1'b1;
  assign o_ready_for_input = ready;
  assign take              = i_input_valid & ready;

  always_comb begin
    pv_d     = 1'b0;
    have_i_d = have_i_q;
    thr_d    = 1'b0;
    pi_d     = pi_q;
    pq_d     = pq_q;
    if (reinit) begin
      have_i_d = 1'b0;
      for (int a = 0; a < MAX_ANT; a++) begin
        pi_d[a] = '0;
        pq_d[a] = '0;
      end
    end else if (take) begin
      if (IN_SPLIT) begin
        pi_d  = i_antenna_i_in;
        pq_d  = i_antenna_q_in;
        pv_d  = 1'b1;
        thr_d = 1'b1;
      end else if (i_input_i_marker) begin
        // a second I word replaces an unpaired first one
        pi_d     = i_antenna_interleaved_in;
        have_i_d = 1'b1;
      end else if (have_i_q) begin
        // a Q word with no I before it is dropped
        pq_d     = i_antenna_interleaved_in;
        pv_d     = 1'b1;
        have_i_d = 1'b0;
      end
    end
    // antennas beyond the configured count stay at zero
    for (int a = NUM_ANT; a < MAX_ANT; a++) begin
      pi_d[a] = '0;
      pq_d[a] = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pv_q     <= 1'b0;
      have_i_q <= 1'b0;
      thr_q    <= 1'b0;
      for (int a = 0; a < MAX_ANT; a++) begin
        pi_q[a] <= '0;
        pq_q[a] <= '0;
      end
    end else if (ce) begin
      pv_q     <= pv_d;
      have_i_q <= have_i_d;
      thr_q    <= thr_d;
      pi_q     <= pi_d;
      pq_q     <= pq_d;
    end
  end

  // clipper hookup
  assign clip_bus.ce       = ce;
  assign clip_bus.reinit   = reinit;
  assign clip_bus.in_valid = pv_q;
  assign clip_bus.in_i     = pi_q;
  assign clip_bus.in_q     = pq_q;
  assign clip_bus.clip     = clip_use;
  assign clip_bus.span     = span_use;
  assign clip_bus.weight   = weight_q[bank_use];

  cfr_peak_clip #(.IW(IW)) u_clip (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (clip_bus.clipper)
  );

  // ------------------------------------------------------------------
  // output gain with saturation to the output width
  function automatic logic signed [OW-1:0] scale_sat(input logic signed [IW-1:0] x,
                                                     input logic [SCALE_W-1:0] g);
    logic signed [IW+SCALE_W-1:0] p;
    logic signed [IW+SCALE_W-1:0] hi;
    hi = $signed({{(IW+SCALE_W-OW+1){1'b0}}, {(OW-1){1'b1}}});
    p  = x * $signed(g);
    p  = p >>> SCALE_FRAC;
    if (p > hi) begin
      scale_sat = hi[OW-1:0];
    end else if (p < -hi - 1) begin
      scale_sat = ~hi[OW-1:0];
    end else begin
      scale_sat = p[OW-1:0];
    end
  endfunction

  cfr_out_state_t       ost_q, ost_d;
  logic                 ov_q, ov_d;
  logic                 om_q, om_d;
  logic signed [OW-1:0] oi_q  [MAX_ANT];
  logic signed [OW-1:0] oi_d  [MAX_ANT];
  logic signed [OW-1:0] oq_q  [MAX_ANT];
  logic signed [OW-1:0] oq_d  [MAX_ANT];
  logic signed [OW-1:0] ol_q  [MAX_ANT];
  logic signed [OW-1:0] ol_d  [MAX_ANT];
  logic signed [OW-1:0] qh_q  [MAX_ANT];
  logic signed [OW-1:0] qh_d  [MAX_ANT];

  // output sequencer; valid only rises with a fresh result
  always_comb begin
    ost_d = ost_q;
    ov_d  = 1'b0;
    om_d  = 1'b0;
    oi_d  = oi_q;
    oq_d  = oq_q;
    ol_d  = ol_q;
    qh_d  = qh_q;
    if (reinit) begin
      ost_d = CFR_OUT_IDLE;
      for (int a = 0; a < MAX_ANT; a++) begin
        oi_d[a] = '0;
        oq_d[a] = '0;
        ol_d[a] = '0;
        qh_d[a] = '0;
      end
    end else if (OUT_SPLIT) begin
      if (clip_bus.res_valid) begin
        for (int a = 0; a < NUM_ANT; a++) begin
          oi_d[a] = scale_sat(clip_bus.res_i[a], scale_use);
          oq_d[a] = scale_sat(clip_bus.res_q[a], scale_use);
        end
        ov_d = 1'b1;
      end
    end else begin
      unique case (ost_q)
        CFR_OUT_IDLE: begin
          if (clip_bus.res_valid) begin
            for (int a = 0; a < NUM_ANT; a++) begin
              ol_d[a] = scale_sat(clip_bus.res_i[a], scale_use);
              qh_d[a] = scale_sat(clip_bus.res_q[a], scale_use);
            end
            ov_d  = 1'b1;
            om_d  = 1'b1;
            ost_d = CFR_OUT_QPEND;
          end
        end
        CFR_OUT_QPEND: begin
          ol_d  = qh_q;
          ov_d  = 1'b1;
          om_d  = 1'b0;
          ost_d = CFR_OUT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ost_q <= CFR_OUT_IDLE;
      ov_q  <= 1'b0;
      om_q  <= 1'b0;
      for (int a = 0; a < MAX_ANT; a++) begin
        oi_q[a] <= '0;
        oq_q[a] <= '0;
        ol_q[a] <= '0;
        qh_q[a] <= '0;
      end
    end else if (ce) begin
      ost_q <= ost_d;
      ov_q  <= ov_d;
      om_q  <= om_d;
      oi_q  <= oi_d;
      oq_q  <= oq_d;
      ol_q  <= ol_d;
      qh_q  <= qh_d;
    end
  end

  assign o_output_valid            = ov_q;
  assign o_output_i_marker         = om_q;
  assign o_antenna_i_out           = oi_q;
  assign o_antenna_q_out           = oq_q;
  assign o_antenna_interleaved_out = ol_q;

endmodule

// file: bench/cfr_ports_checker.sv
// assertions on the crest factor reduction ports
`timescale 1ns/1ps
module cfr_ports_checker
  import cfr_pkg::*;
#(
  parameter int unsigned OW = 16
) (
  // clock, resets, enables
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_srst,
  input wire logic                 i_ce,
  input wire logic                 i_sync_reinit,
  // stream and bus
  input wire logic                 i_input_valid,
  input wire logic                 o_ready_for_input,
  input wire logic                 o_output_valid,
  input wire logic                 o_output_i_marker,
  input wire logic signed [OW-1:0] o_antenna_i_out [MAX_ANT],
  input wire logic                 i_avs_read,
  input wire logic                 i_avs_write,
  input wire logic                 o_avs_waitrequest
);
  logic acc;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n || i_srst);
  // a sample counts only when enabled, so frozen cycles never look like accepts
  assign acc = i_input_valid && o_ready_for_input && i_ce;
  chk_out_latency:
    assert property (acc && !i_sync_reinit ##1 (i_ce && !i_sync_reinit)[*2] |-> ##1
      o_output_valid) else $error("late output");
  chk_out_cause:
    assert property (o_output_valid && $past(i_ce) |-> $past(acc, 3))
      else $error("stray output");
  chk_split_marker:
    assert property (!o_output_i_marker) else $error("marker in split mode");
  chk_split_ready:
    assert property (i_ce |-> o_ready_for_input) else $error("ready dropped");
  chk_ce_freeze:
    assert property (!i_ce |=> $stable(o_output_valid) && $stable(o_antenna_i_out[0]))
      else $error("state moved with enable low");
  chk_reinit_flush:
    assert property (i_sync_reinit && i_ce |=> !o_output_valid[*3])
      else $error("output after reinit");
  chk_rst_quiet:
    assert property (disable iff (1'b0) !i_rst_n |-> !o_output_valid &&
      o_antenna_i_out[0] == '0) else $error("output during reset");
  // one wait state per bus request
  chk_bus_wait:
    assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1
      (!i_ce || !$past(i_ce) || !o_avs_waitrequest)) else $error("bus wait state wrong");
endmodule
bind cfr_ports cfr_ports_checker #(.OW(OW)) cfr_ports_checker_inst (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_srst(i_srst), .i_ce(i_ce),
  .i_sync_reinit(i_sync_reinit), .i_input_valid(i_input_valid),
  .o_ready_for_input(o_ready_for_input), .o_output_valid(o_output_valid),
  .o_output_i_marker(o_output_i_marker), .o_antenna_i_out(o_antenna_i_out),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest));

// file: bench/cfr_up_model.sv
// upstream sample source standing in for the baseband logic
`timescale 1ns/1ps
module cfr_up_model (
  // clock and request from the bench, ready from the block
  input  wire logic               i_clk,
  input  wire logic               i_go,
  input  wire logic               i_ready,
  input  wire logic signed [15:0] i_i,
  input  wire logic signed [15:0] i_q,
  // sample lines towards the block
  output logic                    o_valid,
  output logic                    o_marker,
  output logic signed [15:0]      o_i,
  output logic signed [15:0]      o_q
);
  // strobe and words leave on one edge; idle words are inverted so stale data is never reused
  always_ff @(posedge i_clk) begin
    o_valid  <= i_go && i_ready;
    o_marker <= i_go;
    o_i      <= i_go ? i_i : ~i_i;
    o_q      <= i_go ? i_q : ~i_q;
  end
endmodule

// file: bench/cfr_ports_tb_top.sv
// self-checking bench for the crest factor reduction ports
`timescale 1ns/1ps
module cfr_ports_tb_top
  import cfr_pkg::*;
();
  // row: clip level, bank code, sample in, result expected
  typedef struct {
    logic [15:0]        clip;
    logic [1:0]         bank;
    logic signed [15:0] si, sq, ei, eq;
  } cfr_row_t;
  // gain is two, so plain samples double and large ones saturate
  cfr_row_t rows [6] = '{
    '{16'hFFFF, 2'h0, 16'h0064, 16'hFF38, 16'h00C8, 16'hFE70},
    '{16'hFFFF, 2'h0, 16'h4E20, 16'hB1E0, 16'h7FFF, 16'h8000},
    '{16'h0064, 2'h0, 16'h03E8, 16'h0000, 16'h05DC, 16'h0000},
    '{16'h0064, 2'h1, 16'h03E8, 16'h0000, 16'h04E2, 16'h0000},
    '{16'h0064, 2'h2, 16'h03E8, 16'h0000, 16'h03E8, 16'h0000},
    '{16'h0064, 2'h3, 16'h03E8, 16'h0000, 16'h02EE, 16'h0000}};
  logic               i_clk, rst_n, srst, ce, reinit, go, u_v, u_m, rd, wr, wt, ov, om, rdy;
  logic [7:0]         ad;
  logic [31:0]        wd, rdat, q;
  logic [3:0]         be;
  logic signed [15:0] gi, gq, u_i, u_q, ri, rq;
  logic signed [15:0] ai [MAX_ANT], aq [MAX_ANT], zi [MAX_ANT], oi [MAX_ANT], oq [MAX_ANT];
  int                 error_cnt, compares, vcnt;
  // free-running 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  assign ai = '{default: u_i};
  assign aq = '{default: u_q};
  // interleaved lines carry the same word; the split build ignores them
  assign zi = '{default: u_i};
  cfr_up_model cfr_up_model_inst (.i_clk(i_clk), .i_go(go), .i_ready(rdy), .i_i(gi),
    .i_q(gq), .o_valid(u_v), .o_marker(u_m), .o_i(u_i), .o_q(u_q));
  cfr_ports #(.USE_CE(1'b1), .USE_REINIT(1'b1)) cfr_ports_inst (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_srst(srst), .i_ce(ce), .i_sync_reinit(reinit),
    .i_input_valid(u_v), .i_input_i_marker(u_m), .i_antenna_i_in(ai), .i_antenna_q_in(aq),
    .i_antenna_interleaved_in(zi), .o_ready_for_input(rdy), .i_clip_level(16'hFFFF),
    .i_peak_search_span(5'h03), .i_coefficient_bank_choice(2'h0), .i_output_scale(16'h2000),
    .o_output_valid(ov), .o_output_i_marker(om), .o_antenna_i_out(oi),
    .o_antenna_q_out(oq), .o_antenna_interleaved_out(), .i_avs_address(ad),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bus cycle: hold until waitrequest is seen low, release after that edge
  task automatic avs(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    chk(wt, 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask
  // one pair through the stream, waiting a bounded time for the result
  task automatic send(input logic signed [15:0] si, input logic signed [15:0] sq);
    int n;
    n = 0;
    go <= 1'b1;
    gi <= si;
    gq <= sq;
    @(posedge i_clk);
    go <= 1'b0;
    do begin
      @(negedge i_clk);
      n++;
    end while (ov !== 1'b1 && n < 20);
    chk(ov, 1'b1);
    ri = oi[0];
    rq = oq[0];
    @(posedge i_clk);
  endtask
  initial begin
    {rst_n, srst, ce} = 3'b111;
    {reinit, go, rd, wr} = 4'h0;
    {ad, wd, gi, gq, error_cnt, compares, vcnt} = '0;
    be = 4'hF;
    repeat (2) @(posedge i_clk);
    srst <= 1'b0;
    avs(0, REG_SCALE, 0);
    chk(q, 32'h0000_2000);
    avs(0, 8'h40, 0);
    chk(q, 32'h0000_0000);
    avs(1, REG_SCALE, 32'h0000_4000);
    foreach (rows[k]) begin
      avs(1, REG_CLIP, {16'h0000, rows[k].clip});
      avs(1, REG_BANK, {30'h0, rows[k].bank});
      reinit <= 1'b1;
      @(posedge i_clk);
      reinit <= 1'b0;
      @(posedge i_clk);
      send(rows[k].si, rows[k].sq);
      chk(ri, rows[k].ei);
      chk(rq, rows[k].eq);
    end
    // a single byte lane leaves the upper half of the gain alone
    be <= 4'h1;
    avs(1, REG_SCALE, 32'h0000_1234);
    be <= 4'hF;
    avs(0, REG_SCALE, 0);
    chk(q, 32'h0000_4034);
    avs(0, REG_STATUS, 0);
    chk(q, 32'h0001_0001);
    // a sample offered while disabled must vanish
    ce <= 1'b0;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (3) @(posedge i_clk);
    ce <= 1'b1;
    repeat (6) begin
      @(negedge i_clk);
      if (ov === 1'b1) vcnt++;
    end
    chk(vcnt, 0);
    @(posedge i_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    rst_n <= 1'b1;
    @(posedge i_clk);
    avs(0, REG_SCALE, 0);
    chk(q, 32'h0000_2000);
    wrap_up();
  end
  // the whole run takes well under two hundred cycles
  initial begin
    repeat (3000) @(posedge i_clk);
    error_cnt++;
    wrap_up();
  end
endmodule
